// [verilog/slot_target_pkg.sv]
// shared constants and carrier types for the local bus slot target
package slot_target_pkg;

  // address bus carries bits 31 down to 2
  localparam int ADDR_W = 30;

  // claim windows, held as word addresses (address bits 31..2)
  localparam logic [29:0] MEM_BASE  = 30'h0300_0000; // 64 MB window
  localparam logic [29:0] MEM_MASK  = 30'h3F00_0000;
  localparam logic [29:0] IO_BASE   = 30'h0000_0180; // ports 0x0600..
  localparam logic [29:0] IO_MASK   = 30'h0000_3FC0;
  localparam logic [29:0] PAL_BASE  = 30'h0000_01F0; // read-only claim
  localparam logic [29:0] PAL_MASK  = 30'h0000_3FFC;
  // interrupt-acknowledge and special-cycle range, 00..1F
  localparam logic [29:0] LOW_BASE  = 30'h0000_0000;
  localparam logic [29:0] LOW_MASK  = 30'h3FFF_FFF8;
  localparam logic [29:0] IOLO_MASK = 30'h0000_3FF8;

  // worst-case decode settling, in ns, and the clock period
  localparam int CLAIM_SETTLE_NS = 20;
  localparam int CLK_PERIOD_NS   = 5;
  localparam int CLAIM_SETTLE_CYC =
    (CLAIM_SETTLE_NS / CLK_PERIOD_NS) < 1 ? 1 :
    (CLAIM_SETTLE_NS / CLK_PERIOD_NS);

  // reset values of the shared pins: released and high
  localparam logic PIN_IDLE = 1'b1;
  localparam logic OE_OFF   = 1'b1;

  // target handshake states
  typedef enum logic [7:0] {
    ST_IDLE    = 8'h01,
    ST_FIRST   = 8'h02,
    ST_WAIT    = 8'h04,
    ST_SIZE    = 8'h08,
    ST_READY   = 8'h10,
    ST_BURST   = 8'h20,
    ST_BPULSE  = 8'h40,
    ST_RELEASE = 8'h80
  } tgt_state_e;

  // bus cycle status inputs
  typedef struct packed {
    logic [29:0] addr;
    logic        mem_io;
    logic        write_read;
    logic        cycle_start_strobe_n;
    logic        burst_last_n;
    logic        returned_ready_n;
  } bus_in_s;

  // one shared open-drain style pin: level and enable (low = driving)
  typedef struct packed {
    logic level;
    logic oe_n;
  } pin_s;

endpackage

// [verilog/slot_target.sv]
// local bus slot target: address claim and cycle termination handshake
//
// How it works
// (R1) controller or master drives the invalidate strobe; a target only watches.
// (R2) masters pulse invalidate with cycle start on memory cycles only.
// (R3) one request and one grant per slot; grant gives ownership.
// (R4) a pure target never drives its request line; pull-up keeps it high.
// (R5) claim is a combinational decode of address and memory/io status.
// (R6) memory decode starts at bit 31, io decode at bit 15.
// (R7) claim is push-pull, driven high whenever not addressed.
// (R8) read/write enters the decode only for the colour-table window.
// (R9) controller ANDs claims and samples them after decode time.
// (R10) controller samples claim during dma and io-bus master cycles.
// (R11) never claim io 0000-001F or memory 00000000-0000001F.
// (R12) single-cycle ready driven only by the claiming target, in its cycle.
// (R13) ready low at least one clock, driven high, then released.
// (R14) no ready in first T2 except high-speed writes.
// (R15) a 16-bit target asserts the size request; master splits the access.
// (R16) size request cache_invalidate_strobe_n ready by one clock, held until returned ready.
// (R17) burst ready pulses low exactly one clock per burst transfer.
// (R18) ready and burst ready together: burst ready is ignored.
// (R19) burst ready only in claimed bursts, never with cycle start.
// (R20) a target without bursts ends every cycle with single-cycle ready.
// (R21) slot interrupt request is active high and level triggered.
// (R22) the owner pulses cycle start low for exactly one clock.
// (R23) memory/io status is high for memory, low for io.
// (R24) controller returns ready to all slots to mark cycle completion.

`timescale 1ns/1ps

module slot_target
  import slot_target_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire bus_in_s     i_bus,
  input  wire logic        i_high_speed_write,
  input  wire logic        i_half_width_mode,
  input  wire logic        i_burst_capable,
  input  wire logic        i_data_ready,
  input  wire logic        i_interrupt_level,
  output logic             o_target_claim_n,
  output pin_s             o_single_cycle_ready_n,
  output pin_s             o_half_width_request_n,
  output pin_s             o_burst_ready_n,
  output pin_s             o_slot_request_n,
  output logic             o_slot_interrupt_request,
  output logic             o_cycle_start,
  output logic             o_cycle_write,
  output logic             o_cycle_done
);

  // whole module state, registered in one place
  typedef struct packed {
    tgt_state_e state;
    logic       is_write;
    logic       is_burst;
    logic       is_half;
    pin_s       rdy;
    pin_s       hw;
    pin_s       burst_ready_n;
    logic       irq;
    logic       start;
    logic       done;
  } tgt_s;

  tgt_s state_reg;
  tgt_s state_next;
  logic claim_hit;
  logic mem_hit;
  logic io_hit;
  logic pal_hit;
  logic low_hit;

  // masked compare used by every decode window
  function automatic logic win_match(input logic [29:0] a,
                                     input logic [29:0] base,
                                     input logic [29:0] mask);
    win_match = ((a & mask) == (base & mask));
  endfunction

  // claim decode: purely combinational so the controller can sample it
  // within the settle time; latching it on the strobe would be too late
  always_comb begin
    mem_hit = i_bus.mem_io &&
              win_match(i_bus.addr, MEM_BASE, MEM_MASK); // R6 R23
    io_hit  = !i_bus.mem_io &&
              win_match(i_bus.addr, IO_BASE, IO_MASK); // R6
    pal_hit = !i_bus.mem_io && !i_bus.write_read &&
              win_match(i_bus.addr, PAL_BASE, PAL_MASK); // R8
    // low range blocks acknowledge and special cycles, so data/code
    // status need not enter the decode at all
    low_hit = i_bus.mem_io ?
              win_match(i_bus.addr, LOW_BASE, LOW_MASK) :
              win_match(i_bus.addr, LOW_BASE, IOLO_MASK); // R11
    claim_hit = (mem_hit || io_hit || pal_hit) && !low_hit; // R5
  end

  // push-pull claim: always driven, high when not addressed
  assign o_target_claim_n = !claim_hit; // R7

  // next-state logic
  always_comb begin
    state_next       = state_reg;
    state_next.start = 1'b0;
    state_next.done  = 1'b0;
    state_next.irq   = i_interrupt_level; // R21
    case (state_reg.state)
      ST_IDLE: begin
        state_next.rdy  = '{level: PIN_IDLE, oe_n: OE_OFF};
        state_next.hw   = '{level: PIN_IDLE, oe_n: OE_OFF};
        state_next.burst_ready_n = '{level: PIN_IDLE, oe_n: OE_OFF};
        // take only cycles we claim; others are left alone
        if (!i_bus.cycle_start_strobe_n && claim_hit) begin // R12
          state_next.start    = 1'b1;
          state_next.is_write = i_bus.write_read;
          state_next.is_half  = i_half_width_mode; // R15
          // bursts only for full-width capable targets
          state_next.is_burst = i_burst_capable && !i_half_width_mode &&
                                i_bus.burst_last_n; // R20
          if (i_bus.write_read && i_high_speed_write) begin // R14
            state_next.state    = ST_WAIT;
            state_next.rdy.oe_n = 1'b0;
            state_next.hw.oe_n  = !i_half_width_mode;
            state_next.burst_ready_n.oe_n = !(i_burst_capable &&
                                     !i_half_width_mode &&
                                     i_bus.burst_last_n);
          end else begin
            // first T2 belongs to the cache controller
            state_next.state = ST_FIRST; // R14 R19
          end
        end
      end
      ST_FIRST: begin
        state_next.state     = ST_WAIT;
        state_next.rdy.oe_n  = 1'b0; // R13
        state_next.hw.oe_n   = !state_reg.is_half;
        state_next.burst_ready_n.oe_n = !state_reg.is_burst;
      end
      ST_WAIT: begin
        if (i_data_ready) begin
          if (state_reg.is_half) begin
            // size request cache_invalidate_strobe_n single-cycle ready by one clock
            state_next.state    = ST_SIZE;
            state_next.hw.level = 1'b0; // R16
          end else if (state_reg.is_burst) begin
            state_next.state      = ST_BPULSE;
            state_next.burst_ready_n.level = 1'b0; // R17
          end else begin
            state_next.state     = ST_READY;
            state_next.rdy.level = 1'b0; // R13
          end
        end
      end
      ST_SIZE: begin
        state_next.state     = ST_READY;
        state_next.rdy.level = 1'b0; // R16
      end
      ST_READY: begin
        // hold both lines until returned ready is seen low
        if (!i_bus.returned_ready_n) begin // R13 R16 R24
          state_next.state     = ST_RELEASE;
          state_next.rdy.level = PIN_IDLE;
          state_next.hw.level  = PIN_IDLE;
          state_next.done      = 1'b1;
        end
      end
      ST_BPULSE: begin
        // exactly one clock low, then high between transfers
        state_next.burst_ready_n.level = PIN_IDLE; // R17
        if (!i_bus.burst_last_n) begin
          state_next.state = ST_RELEASE;
          state_next.done  = 1'b1;
        end else begin
          state_next.state = ST_BURST;
        end
      end
      ST_BURST: begin
        if (i_data_ready) begin
          state_next.state      = ST_BPULSE;
          state_next.burst_ready_n.level = 1'b0; // R17
        end
      end
      ST_RELEASE: begin
        // lines were driven high last clock; now let the pull-ups hold
        state_next.state = ST_IDLE;
        state_next.rdy   = '{level: PIN_IDLE, oe_n: OE_OFF}; // R13
        state_next.hw    = '{level: PIN_IDLE, oe_n: OE_OFF}; // R16
        state_next.burst_ready_n  = '{level: PIN_IDLE, oe_n: OE_OFF}; // R19
      end
      default: begin
        state_next.state = ST_IDLE;
        state_next.rdy   = '{level: PIN_IDLE, oe_n: OE_OFF};
        state_next.hw    = '{level: PIN_IDLE, oe_n: OE_OFF};
        state_next.burst_ready_n  = '{level: PIN_IDLE, oe_n: OE_OFF};
      end
    endcase
  end

  // single state register, synchronous active-low reset
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state_reg.state    <= ST_IDLE;
      state_reg.is_write <= 1'b0;
      state_reg.is_burst <= 1'b0;
      state_reg.is_half  <= 1'b0;
      state_reg.rdy      <= '{level: PIN_IDLE, oe_n: OE_OFF};
      state_reg.hw       <= '{level: PIN_IDLE, oe_n: OE_OFF};
      state_reg.burst_ready_n     <= '{level: PIN_IDLE, oe_n: OE_OFF};
      state_reg.irq      <= 1'b0;
      state_reg.start    <= 1'b0;
      state_reg.done     <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // pins straight from the state register
  assign o_single_cycle_ready_n   = state_reg.rdy;
  assign o_half_width_request_n   = state_reg.hw;
  assign o_burst_ready_n          = state_reg.burst_ready_n;
  // never a master: request stays released, pull-up reads it inactive
  assign o_slot_request_n = '{level: PIN_IDLE, oe_n: OE_OFF}; // R3 R4
  assign o_slot_interrupt_request = state_reg.irq;
  assign o_cycle_start            = state_reg.start;
  assign o_cycle_write            = state_reg.is_write;
  assign o_cycle_done             = state_reg.done;

  // checks on the handshake
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  property p_no_low_claim;
    (i_bus.addr & LOW_MASK) == 30'h0 |-> o_target_claim_n;
  endproperty
  a_no_low_claim: assert property (p_no_low_claim) // R11
    else $error("claim asserted in reserved low range");

  property p_pal_write;
    !i_bus.mem_io && i_bus.write_read && !io_hit |-> o_target_claim_n;
  endproperty
  a_pal_write: assert property (p_pal_write) // R8
    else $error("io write claimed outside the io window");

  property p_first_t2;
    !i_bus.cycle_start_strobe_n && claim_hit && state_reg.state == ST_IDLE
      && !(i_bus.write_read && i_high_speed_write)
      |=> o_single_cycle_ready_n.oe_n && o_burst_ready_n.oe_n;
  endproperty
  a_first_t2: assert property (p_first_t2) // R14
    else $error("ready driven in first T2");

  property p_size_lead;
    $fell(o_single_cycle_ready_n.level) && state_reg.is_half
      |-> !$past(o_half_width_request_n.level);
  endproperty
  a_size_lead: assert property (p_size_lead) // R16
    else $error("size request did not lead ready");

  property p_ready_hold;
    !o_single_cycle_ready_n.level && i_bus.returned_ready_n
      |=> !o_single_cycle_ready_n.level;
  endproperty
  a_ready_hold: assert property (p_ready_hold) // R13
    else $error("ready dropped before returned ready");

  property p_high_before_release;
    $rose(o_single_cycle_ready_n.oe_n)
      |-> $past(o_single_cycle_ready_n.level);
  endproperty
  a_high_before_release: assert property (p_high_before_release) // R13
    else $error("ready released while low");

  property p_burst_pulse;
    !o_burst_ready_n.level |=> o_burst_ready_n.level;
  endproperty
  a_burst_pulse: assert property (p_burst_pulse) // R17
    else $error("burst ready low longer than one clock");

  property p_not_both;
    !(!o_burst_ready_n.level && !o_single_cycle_ready_n.level);
  endproperty
  a_not_both: assert property (p_not_both) // R18
    else $error("both ready lines low together");

  property p_ready_owned;
    !o_single_cycle_ready_n.oe_n |-> state_reg.state != ST_IDLE;
  endproperty
  a_ready_owned: assert property (p_ready_owned) // R12
    else $error("ready driven outside a claimed cycle");

  property p_irq_level;
    i_interrupt_level |=> o_slot_interrupt_request;
  endproperty
  a_irq_level: assert property (p_irq_level) // R21
    else $error("interrupt request not following level");

  property p_single_done;
    o_cycle_start ##1 (!o_single_cycle_ready_n.level)[*2];
  endproperty
  c_single_done: cover property (p_single_done);
  c_half: cover property (!o_half_width_request_n.level ##1
                          !o_single_cycle_ready_n.level);
  c_burst: cover property (!o_burst_ready_n.level ##2
                           !o_burst_ready_n.level);
  c_hsw: cover property (o_cycle_start && o_cycle_write &&
                         !o_single_cycle_ready_n.oe_n);

endmodule

// [tb/bus_ctrl_model.sv]
// controller model: runs bus cycles, returns ready, watches target pins
`timescale 1ns/1ps
module bus_ctrl_model
  import slot_target_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_claim_n,
  input  wire pin_s i_rdy,
  input  wire pin_s i_hw,
  input  wire pin_s i_burst_ready_n,
  output bus_in_s   o_bus
);
  int rdy_at, hw_at, rdy_low, hw_low, pulses, flaw, first_drv, claimed;

  // a released pin reads high through the board pull-up
  function automatic logic lvl(input pin_s p);
    return p.oe_n ? 1'b1 : p.level;
  endfunction

  // letting go of a pin last driven low leaves a slow rising edge
  function automatic logic bad_rel(input pin_s p, input pin_s q);
    return p.oe_n && !q.oe_n && !q.level;
  endfunction

  // host owns the bus: no burst, no cycle, ready high
  initial begin
    o_bus = {30'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1};
  end

  task automatic put_addr(input logic [29:0] a, input logic m,
                          input logic w);
    @(negedge i_clk);
    o_bus.addr       = a;
    o_bus.mem_io     = m;
    o_bus.write_read = w;
  endtask

  // one memory cycle; beats above one asks for a burst, dly stalls return
  task automatic run(input logic w, input int beats, input int dly);
    int   n;
    pin_s pr, ph, pb;
    n         = 0;
    rdy_at    = -1;
    hw_at     = -1;
    rdy_low   = 0;
    hw_low    = 0;
    pulses    = 0;
    flaw      = 0;
    first_drv = 0;
    pr        = i_rdy;
    ph        = i_hw;
    pb        = i_burst_ready_n;
    put_addr(MEM_BASE + 30'h10, 1'b1, w);
    o_bus.burst_last_n         = (beats > 1);
    o_bus.cycle_start_strobe_n = 1'b0;
    @(posedge i_clk);
    claimed = !i_claim_n;
    if (!i_burst_ready_n.oe_n) flaw = 1;
    @(negedge i_clk);
    o_bus.cycle_start_strobe_n = 1'b1;
    while (n < 60 &&
           !(n > 2 && pr.oe_n && ph.oe_n && pb.oe_n)) begin
      @(posedge i_clk);
      n++;
      if (n == 1 && !(i_rdy.oe_n && i_burst_ready_n.oe_n)) first_drv = 1;
      if (!lvl(i_hw)) begin
        hw_low++;
        if (hw_at < 0) hw_at = n;
      end
      if (!lvl(i_rdy)) begin
        rdy_low++;
        if (rdy_at < 0) rdy_at = n;
      end else if (!lvl(i_burst_ready_n)) begin
        pulses++;
        if (!lvl(pb)) flaw = 1;
      end
      if (bad_rel(i_rdy, pr) || bad_rel(i_hw, ph) || bad_rel(i_burst_ready_n, pb))
        flaw = 1;
      pr = i_rdy;
      ph = i_hw;
      pb = i_burst_ready_n;
      @(negedge i_clk);
      // ready comes back once, dly clocks after the target asked
      o_bus.returned_ready_n = !(!lvl(i_rdy) && rdy_low == dly + 1);
      if (beats > 1 && pulses >= beats - 1) o_bus.burst_last_n = 1'b0;
    end
    if (n >= 60) flaw = 1;
    // host drives burst last low again; skip if the loop just did
    if (o_bus.burst_last_n) o_bus.burst_last_n = 1'b0;
  endtask

  // a cycle start at an address this slot must leave alone
  task automatic strobe_only(input logic [29:0] a);
    put_addr(a, 1'b1, 1'b0);
    o_bus.cycle_start_strobe_n = 1'b0;
    @(negedge i_clk);
    o_bus.cycle_start_strobe_n = 1'b1;
  endtask
endmodule

// [tb/slot_target_tb.sv]
// self-checking bench for the slot target
`timescale 1ns/1ps
module slot_target_tb;
  import slot_target_pkg::*;
  logic    clk, resetn, hsw, half, bcap, dready, irq_in;
  logic    claim_n, irq, cstart, cwrite, cdone;
  bus_in_s bus;
  pin_s    rdy, hw, burst_ready_n, req;
  int      error_cnt = 0;
  int      n_compared = 0;
  int      dones = 0;
  int      starts = 0;

  slot_target DUT (
    .i_clk(clk), .i_resetn(resetn), .i_bus(bus),
    .i_high_speed_write(hsw), .i_half_width_mode(half),
    .i_burst_capable(bcap), .i_data_ready(dready),
    .i_interrupt_level(irq_in), .o_target_claim_n(claim_n),
    .o_single_cycle_ready_n(rdy), .o_half_width_request_n(hw),
    .o_burst_ready_n(burst_ready_n), .o_slot_request_n(req),
    .o_slot_interrupt_request(irq), .o_cycle_start(cstart),
    .o_cycle_write(cwrite), .o_cycle_done(cdone)
  );

  bus_ctrl_model ctrl (
    .i_clk(clk), .i_claim_n(claim_n), .i_rdy(rdy), .i_hw(hw),
    .i_burst_ready_n(burst_ready_n), .o_bus(bus)
  );

  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end

  // started and completed cycles, compared at the end of the run
  always @(posedge clk) begin
    if (cdone === 1'b1) dones <= dones + 1;
    if (cstart === 1'b1) starts <= starts + 1;
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // one cycle judged on its common handshake figures
  task automatic cyc(input logic w, input int beats, input int dly,
                     input int e_at, input int e_first);
    ctrl.run(w, beats, dly);
    check("claimed", ctrl.claimed, 1);
    check("first_t2", ctrl.first_drv, e_first);
    check("ready_at", ctrl.rdy_at, e_at);
    check("ready_low", ctrl.rdy_low, e_at < 0 ? 0 : 2 + dly);
    check("flaw", ctrl.flaw, 0);
    check("cycle_write", cwrite, w);
  endtask

  // a strobe for another target must start nothing here
  task automatic t_unclaimed;
    ctrl.strobe_only(30'h2300_0010);
    check("start", cstart, 0);
    @(negedge clk);
    check("ready_pin", rdy, 2'h3);
  endtask

  task automatic t_reset;
    check("ready_pin", rdy, 2'h3);
    check("size_pin", hw, 2'h3);
    check("burst_pin", burst_ready_n, 2'h3);
    check("request_pin", req, 2'h3);
    check("irq", irq, 0);
  endtask

  // windows, low range, top address bits, read-only window, space bit
  task automatic t_claim;
    logic [31:0] tab [9] = '{{30'h0300_0010, 2'h2}, {30'h2300_0010, 2'h2},
      {30'h4, 2'h2}, {30'h180, 2'h0}, {30'h2180, 2'h0}, {30'h4, 2'h0},
      {30'h1F0, 2'h0}, {30'h1F0, 2'h1}, {30'h0300_0010, 2'h0}};
    logic [29:0] a;
    logic        m, w, e;
    foreach (tab[i]) begin
      {a, m, w} = tab[i];
      ctrl.put_addr(a, m, w);
      #1;
      e = m ? (a & MEM_MASK) == MEM_BASE && (a & LOW_MASK) != 0
            : ((a & IO_MASK) == IO_BASE || (a & PAL_MASK) == PAL_BASE && !w)
              && (a & IOLO_MASK) != 0;
      check("claim", claim_n, !e);
    end
  endtask

  task automatic t_plain;
    cyc(1'b0, 1, 0, 3, 0);
    check("size_at", ctrl.hw_at, -1);
    cyc(1'b0, 1, 3, 3, 0);
  endtask

  // the fast write path opens the first T2 to writes only
  task automatic t_hsw;
    hsw = 1'b1;
    cyc(1'b1, 1, 0, 2, 1);
    cyc(1'b0, 1, 0, 3, 0);
    hsw = 1'b0;
  endtask

  task automatic t_half;
    half = 1'b1;
    cyc(1'b0, 1, 0, 4, 0);
    check("size_at", ctrl.hw_at, 3);
    check("size_low", ctrl.hw_low, 3);
    half = 1'b0;
  endtask

  task automatic t_burst;
    bcap = 1'b1;
    cyc(1'b0, 4, 0, -1, 0);
    check("pulses", ctrl.pulses, 4);
    bcap = 1'b0;
    cyc(1'b0, 4, 0, 3, 0);
    check("pulses", ctrl.pulses, 0);
  endtask

  // target stalls until its data is ready
  task automatic t_slow_data;
    dready = 1'b0;
    fork
      cyc(1'b0, 1, 0, 5, 0);
      begin
        repeat (5) @(negedge clk);
        dready = 1'b1;
      end
    join
  endtask

  task automatic t_irq;
    irq_in = 1'b1;
    @(negedge clk);
    check("irq", irq, 1);
    irq_in = 1'b0;
    @(negedge clk);
    check("irq", irq, 0);
  endtask

  initial begin
    resetn = 0;
    hsw    = 0;
    half   = 0;
    bcap   = 0;
    dready = 1;
    irq_in = 0;
    repeat (12) @(negedge clk);
    t_reset();
    resetn = 1;
    t_claim();
    t_unclaimed();
    t_plain();
    t_hsw();
    t_half();
    t_burst();
    t_slow_data();
    t_irq();
    check("done_count", dones, 8);
    check("start_count", starts, 8);
    check("request_pin", req, 2'h3);
    tally_and_finish();
  end

  // a hang anywhere ends the run as a mismatch
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end
endmodule
